/* design/dsth_pkg.sv */
// package: constants, types and field layout for the stream touch hint decoder
package dsth_pkg;
  localparam int DSTH_XLEN = 64;
  localparam int DSTH_NSTREAM = 16;
  localparam logic [4:0] DSTH_HINT_DESC = 5'h08;
  localparam logic [4:0] DSTH_HINT_CTRL = 5'h0A;
  // operand bits numbered 0 = msb, converted to lsb indices
  localparam int DSTH_START_HI = 63;
  localparam int DSTH_START_LO = 7;
  localparam int DSTH_DIR_BIT = 6;
  localparam int DSTH_UNL_BIT = 5;
  localparam int DSTH_ID_HI = 3;
  localparam int DSTH_ID_LO = 0;
  localparam int DSTH_GO_BIT = 31;
  localparam int DSTH_STOP_HI = 30;
  localparam int DSTH_STOP_LO = 29;
  localparam int DSTH_LEN_HI = 16;
  localparam int DSTH_LEN_LO = 7;
  localparam int DSTH_TRANS_BIT = 6;
  localparam logic [1:0] DSTH_STOP_NONE = 2'h0;
  localparam logic [1:0] DSTH_STOP_RSVD = 2'h1;
  localparam logic [1:0] DSTH_STOP_ONE = 2'h2;
  localparam logic [1:0] DSTH_STOP_ALL = 2'h3;
  localparam logic [56:0] DSTH_START_RST = 57'h0;
  localparam logic [9:0] DSTH_LEN_RST = 10'h0;
  localparam logic [31:0] DSTH_PRDATA_RST = 32'h0;
  // apb register map
  localparam logic [11:0] DSTH_REG_CTRL = 12'h000;
  localparam logic [11:0] DSTH_REG_ACTIVE = 12'h004;
  localparam logic [11:0] DSTH_REG_NASCENT = 12'h008;
  localparam logic [11:0] DSTH_REG_COUNT = 12'h00C;
  localparam int DSTH_CTRL_EN_BIT = 0;

  typedef struct packed {
    logic valid;
    logic [4:0] touchHint;
    logic baseIsZero;
    logic [63:0] baseRegister;
    logic [63:0] offsetRegister;
    logic inhibited;
    logic guarded;
  } dsth_req_s;

  typedef struct packed {
    logic [56:0] streamStartHigh;
    logic downward;
    logic unlimited;
    logic transient;
    logic [9:0] streamLength;
    logic described;
    logic nascent;
    logic active;
  } dsth_entry_s;
endpackage : dsth_pkg

/* design/dsth_ea_calc.sv */
// effective address adder for the touch operand
`timescale 1ns/1ps
module dsth_ea_calc (
  // operands
  input wire logic baseIsZero,
  input wire logic [dsth_pkg::DSTH_XLEN-1:0] baseRegister,
  input wire logic [dsth_pkg::DSTH_XLEN-1:0] offsetRegister,
  // result
  output logic [dsth_pkg::DSTH_XLEN-1:0] operand
);
  import dsth_pkg::*;
  always_comb begin
    if (baseIsZero) begin
      operand = offsetRegister;
    end else begin
      operand = baseRegister + offsetRegister;
    end
  end
endmodule : dsth_ea_calc

/* design/dsth_apb_regs.sv */
// apb slave for control and status of the stream table
`timescale 1ns/1ps
module dsth_apb_regs (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // block state
  input wire logic [15:0] activeMask,
  input wire logic [15:0] nascentMask,
  input wire logic [15:0] hintCount,
  output logic enable
);
  import dsth_pkg::*;
  logic [31:0] next_prdata;
  logic next_enable;
  logic access;

  assign access = psel && penable;
  assign pready = 1'b1;
  // unmapped addresses answer with an error
  assign pslverr = access && !(paddr == DSTH_REG_CTRL || paddr == DSTH_REG_ACTIVE
                   || paddr == DSTH_REG_NASCENT || paddr == DSTH_REG_COUNT);

  always_comb begin
    next_enable = enable;
    next_prdata = prdata;
    if (access && pwrite && paddr == DSTH_REG_CTRL) begin
      next_enable = pwdata[DSTH_CTRL_EN_BIT];
    end
    if (psel && !penable && !pwrite) begin
      if (paddr == DSTH_REG_CTRL) begin
        next_prdata = {31'h0, enable};
      end else if (paddr == DSTH_REG_ACTIVE) begin
        next_prdata = {16'h0, activeMask};
      end else if (paddr == DSTH_REG_NASCENT) begin
        next_prdata = {16'h0, nascentMask};
      end else if (paddr == DSTH_REG_COUNT) begin
        next_prdata = {16'h0, hintCount};
      end else begin
        next_prdata = DSTH_PRDATA_RST;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable <= 1'b1;
      prdata <= DSTH_PRDATA_RST;
    end else begin
      enable <= next_enable;
      prdata <= next_prdata;
    end
  end
endmodule : dsth_apb_regs

/* design/dsth_decoder.sv */
// stream touch hint decoder with a sixteen entry prefetch stream table
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - hint 01000 decodes stream description, 01010 decodes stream control
// - operand is base plus offset, offset alone when base field is zero
// - inhibited or guarded targets ignored; never raises an error
// - description form: operand bits 0..56 give stream start high part
// - description bit 57 selects upward or downward direction
// - description bit 58 marks unlimited, not transient, load soon
// - bits 60..63 select one of sixteen stream entries
// - control bit 32 with stop code 00 or 01 activates described nascent streams, deactivates others
// - stop code 00 carries nothing, code 01 is reserved
// - stop code 10 stops only the numbered stream
// - stop code 11 stops every stream, ignoring all other fields
// - control bits 47..56 give the stream length in units
// - control bit 57 marks the stream transient
// - control bit 58 marks unlimited and ignores the length
// - condition field zero and fixed point exceptions stay unchanged
module dsth_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // touch request from load/store pipeline
  input wire dsth_pkg::dsth_req_s req,
  // prefetcher side
  input wire logic [3:0] queryNumber,
  output dsth_pkg::dsth_entry_s queryEntry,
  output logic [15:0] activeMask,
  output logic tableUpdated,
  // status kept untouched toward the core
  output logic crWrite,
  output logic xerWrite,
  output logic errorTrap
);
  import dsth_pkg::*;

  // ----------------------------------------------------------------
  // operand forming
  // ----------------------------------------------------------------
  logic [63:0] operand;
  logic enable;
  logic [15:0] nascentMask;
  logic [15:0] hintCount;
  logic [15:0] next_hintCount;

  dsth_ea_calc u_ea (
    .baseIsZero(req.baseIsZero),
    .baseRegister(req.baseRegister),
    .offsetRegister(req.offsetRegister),
    .operand(operand)
  );

  dsth_apb_regs u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .activeMask(activeMask),
    .nascentMask(nascentMask),
    .hintCount(hintCount),
    .enable(enable)
  );

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  logic usable;
  logic isDesc;
  logic isCtrl;
  logic [3:0] streamNumber;
  logic [1:0] stopCode;
  logic goFlag;

  // hint dropped for inhibited or guarded storage
  assign usable = req.valid && enable && !req.inhibited && !req.guarded;
  assign isDesc = usable && req.touchHint == DSTH_HINT_DESC;
  assign isCtrl = usable && req.touchHint == DSTH_HINT_CTRL;
  // stream number from low four bits
  assign streamNumber = operand[DSTH_ID_HI:DSTH_ID_LO];
  assign stopCode = operand[DSTH_STOP_HI:DSTH_STOP_LO];
  assign goFlag = operand[DSTH_GO_BIT];

  // ----------------------------------------------------------------
  // stream table
  // ----------------------------------------------------------------
  dsth_entry_s streams [DSTH_NSTREAM];
  dsth_entry_s next_streams [DSTH_NSTREAM];
  logic next_tableUpdated;

  always_comb begin
    for (int i = 0; i < DSTH_NSTREAM; i++) begin
      next_streams[i] = streams[i];
    end
    next_tableUpdated = isDesc || isCtrl;
    next_hintCount = hintCount + 16'((isDesc || isCtrl) ? 1 : 0);
    if (isDesc) begin
      next_streams[streamNumber].streamStartHigh = operand[DSTH_START_HI:DSTH_START_LO];
      next_streams[streamNumber].downward = operand[DSTH_DIR_BIT];
      next_streams[streamNumber].nascent = 1'b1;
      next_streams[streamNumber].described = 1'b1;
      // unlimited go: unlimited, not transient, load soon
      if (operand[DSTH_UNL_BIT]) begin
        next_streams[streamNumber].unlimited = 1'b1;
        next_streams[streamNumber].transient = 1'b0;
        next_streams[streamNumber].active = 1'b1;
        next_streams[streamNumber].nascent = 1'b0;
      end
    end else if (isCtrl) begin
      // stop all, every other field ignored
      if (stopCode == DSTH_STOP_ALL) begin
        for (int i = 0; i < DSTH_NSTREAM; i++) begin
          next_streams[i].active = 1'b0;
          next_streams[i].nascent = 1'b0;
        end
      end else if (stopCode == DSTH_STOP_ONE) begin
        next_streams[streamNumber].active = 1'b0;
        next_streams[streamNumber].nascent = 1'b0;
      end else begin
        // codes 00 and 01 carry no stop information
        next_streams[streamNumber].streamLength = operand[DSTH_LEN_HI:DSTH_LEN_LO];
        if (operand[DSTH_TRANS_BIT]) begin
          next_streams[streamNumber].transient = 1'b1;
        end
        if (operand[DSTH_UNL_BIT]) begin
          next_streams[streamNumber].unlimited = 1'b1;
          next_streams[streamNumber].streamLength = DSTH_LEN_RST;
        end
        // go activates fully described nascent streams
        if (goFlag) begin
          for (int i = 0; i < DSTH_NSTREAM; i++) begin
            if (next_streams[i].nascent && next_streams[i].described) begin
              next_streams[i].active = 1'b1;
              next_streams[i].nascent = 1'b0;
            end else begin
              next_streams[i].active = 1'b0;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DSTH_NSTREAM; i++) begin
        streams[i] <= '0;
      end
      tableUpdated <= 1'b0;
      hintCount <= 16'h0000;
    end else begin
      for (int i = 0; i < DSTH_NSTREAM; i++) begin
        streams[i] <= next_streams[i];
      end
      tableUpdated <= next_tableUpdated;
      hintCount <= next_hintCount;
    end
  end

  always_comb begin
    for (int i = 0; i < DSTH_NSTREAM; i++) begin
      activeMask[i] = streams[i].active;
      nascentMask[i] = streams[i].nascent;
    end
  end

  assign queryEntry = streams[queryNumber];
  // no condition or exception update; no error handler
  assign crWrite = 1'b0;
  assign xerWrite = 1'b0;
  assign errorTrap = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_desc_start: assert property (isDesc |=> streams[$past(streamNumber)].streamStartHigh
    == $past(operand[DSTH_START_HI:DSTH_START_LO])) else $error("start not stored");
  a_desc_dir: assert property (isDesc |=> streams[$past(streamNumber)].downward
    == $past(operand[DSTH_DIR_BIT])) else $error("direction not stored");
  a_desc_go: assert property (isDesc && operand[DSTH_UNL_BIT] |=>
    activeMask[$past(streamNumber)] && !streams[$past(streamNumber)].transient)
    else $error("unlimited go not applied");
  a_guard_drop: assert property (req.valid && (req.inhibited || req.guarded) |=>
    !tableUpdated) else $error("guarded hint used");
  a_stop_all: assert property (isCtrl && stopCode == DSTH_STOP_ALL |=> activeMask == 16'h0000)
    else $error("stop all failed");
  a_stop_one: assert property (isCtrl && stopCode == DSTH_STOP_ONE |=>
    !activeMask[$past(streamNumber)] && ((activeMask | (16'h1 << $past(streamNumber)))
    == ($past(activeMask) | (16'h1 << $past(streamNumber))))) else $error("stop one failed");
  a_ctrl_len: assert property (isCtrl && !stopCode[1] && !operand[DSTH_UNL_BIT] |=>
    streams[$past(streamNumber)].streamLength == $past(operand[DSTH_LEN_HI:DSTH_LEN_LO]))
    else $error("length not stored");
  a_ctrl_trans: assert property (isCtrl && !stopCode[1] && operand[DSTH_TRANS_BIT] |=>
    streams[$past(streamNumber)].transient) else $error("transient not set");
  a_ctrl_unl: assert property (isCtrl && !stopCode[1] && operand[DSTH_UNL_BIT] |=>
    streams[$past(streamNumber)].unlimited) else $error("unlimited not set");
  a_go_nascent: assert property (isCtrl && !stopCode[1] && goFlag |=> nascentMask == 16'h0000)
    else $error("go left bad state");
  a_no_status: assert property (req.valid |-> ##[0:2] (!crWrite && !xerWrite && !errorTrap))
    else $error("status written");
  c_desc: cover property (isDesc);
  c_go: cover property (isCtrl && goFlag && !stopCode[1]);
  c_stop_all: cover property (isCtrl && stopCode == DSTH_STOP_ALL);
  c_stop_one: cover property (isCtrl && stopCode == DSTH_STOP_ONE);
endmodule : dsth_decoder

/* testbench/dsth_prefetch_model.sv */
// prefetcher model: looks at table entries and tallies table updates
`timescale 1ns/1ps
module dsth_prefetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // decoder side
  input wire logic tableUpdated,
  input wire dsth_pkg::dsth_entry_s queryEntry,
  output logic [3:0] queryNumber,
  // bench side
  input wire logic [3:0] pick,
  output dsth_pkg::dsth_entry_s seen,
  output logic [15:0] updates
);
  import dsth_pkg::*;
  logic [15:0] next_updates;
  // one pulse per accepted hint, so the tally doubles as a hint count
  always_comb begin
    queryNumber = pick;
    seen = queryEntry;
    next_updates = tableUpdated ? updates + 16'h1 : updates;
  end
  always_ff @(posedge clk) begin
    updates <= sys_rst ? 16'h0 : next_updates;
  end
endmodule : dsth_prefetch_model

/* testbench/data_stream_touch_hint_decoder_bench.sv */
// self-checking bench for the stream touch hint decoder
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module data_stream_touch_hint_decoder_bench;
  import dsth_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  dsth_req_s req;
  logic [3:0] queryNumber, pick;
  dsth_entry_s queryEntry, seen;
  logic [15:0] activeMask, updates;
  logic tableUpdated, crWrite, xerWrite, errorTrap;
  int miscompares, totalChecks, cycles, accepted;
  localparam logic [56:0] S1 = 57'h1_2345_6789_ABCD;
  localparam logic [56:0] S2 = 57'h0_0F0F_0F0F_0F0F;
  dsth_decoder DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .queryNumber(queryNumber), .queryEntry(queryEntry),
    .activeMask(activeMask), .tableUpdated(tableUpdated), .crWrite(crWrite),
    .xerWrite(xerWrite), .errorTrap(errorTrap));
  dsth_prefetch_model farSide (.clk(clk), .sys_rst(sys_rst), .tableUpdated(tableUpdated),
    .queryEntry(queryEntry), .queryNumber(queryNumber), .pick(pick), .seen(seen),
    .updates(updates));
  // ----------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // base plus offset, or offset alone with junk in base when the base field is zero
  task automatic touch(input logic [4:0] th, input logic [63:0] op, input logic bz,
      input logic inh, input logic grd, input logic expU);
    @(posedge clk);
    req <= '{1'b1, th, bz, bz ? 64'h5A5A_0000_0000_1111 : op - 64'h1234,
      bz ? op : 64'h1234, inh, grd};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    `CHK(tableUpdated, expU)
    `CHK({crWrite, xerWrite, errorTrap}, 3'h0)
    if (expU) accepted++;
  endtask : touch
  task automatic look(input logic [3:0] n);
    @(posedge clk);
    pick <= n;
    #1;
  endtask : look
  // reserved bits are always set to show they are ignored
  function automatic logic [63:0] desc(input logic [56:0] s, input logic d, input logic u,
      input logic [3:0] id);
    return {s, d, u, 1'b1, id};
  endfunction : desc
  function automatic logic [63:0] ctrl(input logic go, input logic [1:0] st,
      input logic [9:0] len, input logic t, input logic u, input logic [3:0] id);
    return {32'hFFFF_FFFF, go, st, 12'hFFF, len, t, u, 1'b1, id};
  endfunction : ctrl
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_describe();
    touch(DSTH_HINT_DESC, desc(S1, 1'b0, 1'b0, 4'h5), 1'b0, 1'b0, 1'b0, 1'b1);
    look(4'h5);
    `CHK(seen.streamStartHigh, S1)
    `CHK(seen.downward, 1'b0)
    `CHK(seen.described, 1'b1)
    `CHK(activeMask, 16'h0000)
    touch(DSTH_HINT_DESC, desc(S2, 1'b1, 1'b0, 4'h6), 1'b1, 1'b0, 1'b0, 1'b1);
    look(4'h6);
    `CHK(seen.streamStartHigh, S2)
    `CHK(seen.downward, 1'b1)
    touch(DSTH_HINT_DESC, desc(S1, 1'b0, 1'b1, 4'h3), 1'b0, 1'b0, 1'b0, 1'b1);
    look(4'h3);
    `CHK({seen.unlimited, seen.transient}, 2'h2)
    `CHK(activeMask, 16'h0008)
    $display("done describe");
  endtask : t_describe
  task automatic t_control();
    touch(DSTH_HINT_CTRL, ctrl(1'b0, 2'h0, 10'h2A5, 1'b1, 1'b0, 4'h5), 1'b0, 1'b0, 1'b0, 1'b1);
    look(4'h5);
    `CHK(seen.streamLength, 10'h2A5)
    `CHK(seen.transient, 1'b1)
    `CHK(seen.unlimited, 1'b0)
    `CHK(activeMask, 16'h0008)
    touch(DSTH_HINT_CTRL, ctrl(1'b0, 2'h0, 10'h155, 1'b0, 1'b1, 4'h6), 1'b0, 1'b0, 1'b0, 1'b1);
    look(4'h6);
    `CHK({seen.unlimited, seen.streamLength}, 11'h400)
    // go with the reserved stop code: nascent 5 and 6 run, stream 3 stops
    touch(DSTH_HINT_CTRL, ctrl(1'b1, 2'h1, 10'h2A5, 1'b1, 1'b0, 4'h5), 1'b0, 1'b0, 1'b0, 1'b1);
    `CHK(activeMask, 16'h0060)
    $display("done control");
  endtask : t_control
  task automatic t_stop();
    touch(DSTH_HINT_CTRL, ctrl(1'b1, 2'h2, 10'h000, 1'b0, 1'b1, 4'h5), 1'b0, 1'b0, 1'b0, 1'b1);
    `CHK(activeMask, 16'h0040)
    look(4'h5);
    `CHK({seen.unlimited, seen.streamLength}, 11'h2A5)
    touch(DSTH_HINT_CTRL, ctrl(1'b1, 2'h3, 10'h000, 1'b0, 1'b0, 4'h0), 1'b0, 1'b0, 1'b0, 1'b1);
    `CHK(activeMask, 16'h0000)
    $display("done stop");
  endtask : t_stop
  task automatic t_refuse();
    logic [4:0] bad [5] = '{5'h00, 5'h01, 5'h03, 5'h09, 5'h18};
    foreach (bad[i]) touch(bad[i], desc(S2, 1'b0, 1'b0, 4'h7), 1'b0, 1'b0, 1'b0, 1'b0);
    touch(DSTH_HINT_DESC, desc(S2, 1'b0, 1'b0, 4'h7), 1'b0, 1'b1, 1'b0, 1'b0);
    touch(DSTH_HINT_DESC, desc(S2, 1'b0, 1'b0, 4'h7), 1'b0, 1'b0, 1'b1, 1'b0);
    apb(1'b1, DSTH_REG_CTRL, 32'h0);
    touch(DSTH_HINT_DESC, desc(S2, 1'b0, 1'b0, 4'h7), 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, DSTH_REG_CTRL, 32'h1);
    look(4'h7);
    `CHK(seen.streamStartHigh, DSTH_START_RST)
    $display("done refuse");
  endtask : t_refuse
  task automatic t_regs();
    apb(1'b0, DSTH_REG_COUNT, 32'h0);
    `CHK(rd[15:0], 16'(accepted))
    `CHK(updates, 16'(accepted))
    apb(1'b0, 12'h010, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    `CHK(pready, 1'b1)
    apb(1'b1, DSTH_REG_ACTIVE, 32'hFFFF);
    apb(1'b0, DSTH_REG_ACTIVE, 32'h0);
    `CHK(rd, 32'h0)
    $display("done registers");
  endtask : t_regs
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, pick} = {1'b1, 51'h0};
    req = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, DSTH_REG_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    t_describe();
    t_control();
    t_stop();
    t_refuse();
    t_regs();
    stop_test();
  end
endmodule : data_stream_touch_hint_decoder_bench
